// file: include/dac_ctrl_cfg.svh
`ifndef DAC_CTRL_CFG_SVH
`define DAC_CTRL_CFG_SVH

// Serial word geometry
`define WORD_BITS        16
`define CODE_BITS        14
`define READBACK_ZERO_MSBS 2
// Reset values
`define SHIFT_RESET      16'h0000
`define CONV_RESET       16'h0000
// Bench link clock period, used only to size nothing in logic
`define LINK_CLK_PERIOD_NS 160

`endif

// file: include/dac_ctrl_pkg.sv
package dac_ctrl_pkg;

    // Pin inputs after synchronisation
    typedef struct packed {
        logic serial_clk;
        logic frame_n;
        logic serial_in;
        logic load_strobe_n;
        logic readback_en_n;
        logic output_clear_n;
        logic power_down_n;
    } pin_in_t;

    // Word leaving the shift side toward the converter register
    typedef struct packed {
        logic [15:0] word;
    } load_word_t;

    // Analog-side control bundle
    typedef struct packed {
        logic [15:0] code;
        logic        clear_active;
        logic        powered_down;
    } analog_ctrl_t;

endpackage

// file: src/dac_load_buffer.sv
`timescale 1ns/1ps
`include "dac_ctrl_cfg.svh"

// Two-entry buffer between the shift register and the converter register
module dac_load_buffer #(
    parameter int WIDTH = `WORD_BITS
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic                  wr_ptr;
        logic                  rd_ptr;
        logic [1:0]            count;
    } buf_state_t;

    buf_state_t cur;
    buf_state_t next_cur;
    logic       push;
    logic       pop;

    // Ready and valid are honest views of the occupancy
    assign in_ready  = (cur.count != 2'h2);
    assign out_valid = (cur.count != 2'h0);
    assign out_data  = cur.mem[cur.rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and count update
    always_comb begin
        next_cur = cur;
        if (push) begin
            next_cur.mem[cur.wr_ptr] = in_data;
            next_cur.wr_ptr = ~cur.wr_ptr;
        end
        if (pop) begin
            next_cur.rd_ptr = ~cur.rd_ptr;
        end
        if (push && !pop) begin
            next_cur.count = cur.count + 2'h1;
        end else if (pop && !push) begin
            next_cur.count = cur.count - 2'h1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end
endmodule

// file: src/dac_serial_ctrl.sv
`timescale 1ns/1ps
`include "dac_ctrl_cfg.svh"
// Overview of operation
// - Sixteen-bit words arrive on serial_in, one bit per falling serial clock edge.
// - Bits shift in while the active-low frame input or the readback enable is low.
// - Load strobe low copies the shift register into the converter register.
// - Strobe held low updates the converter register when the frame rises.
// - Readback enable low presents the converter register on serial_out.
// - Readback bits advance one per rising serial clock edge on serial_out.
// - Outside readback, serial_out passes previously written bits for daisy-chaining.
// - Serial output is open-drain: pull low or release only.
// - Clear falling edge forces analog output to the output-ground reference.
// - Clear leaves shift and converter registers untouched.
// - Power-down input low puts the device in power-down.
// - Strobe sampled at frame fall chooses end-of-frame or deferred update.
// - Without readback, each written bit reaches serial_out sixteen clocks later.
// - Readback enable low loads converter register into shift register next falling edge.
// - Readback word returns its two top bits as zero.

module dac_serial_ctrl
    import dac_ctrl_pkg::*;
#(
    parameter int WORD_BITS = `WORD_BITS,
    parameter int CODE_BITS = `CODE_BITS
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 serial_clk,
    input  wire logic                 frame_n,
    input  wire logic                 serial_in,
    input  wire logic                 load_strobe_n,
    input  wire logic                 readback_en_n,
    input  wire logic                 output_clear_n,
    input  wire logic                 power_down_n,
    output logic                      serial_out_o,
    output logic                      serial_out_oe,
    output dac_ctrl_pkg::analog_ctrl_t analog_ctrl,
    output logic                      load_stall
);
    import dac_ctrl_pkg::*;

    typedef struct packed {
        pin_in_t                sync1;
        pin_in_t                sync2;
        pin_in_t                last;
        logic [WORD_BITS-1:0]   shift;
        logic [4:0]             bit_count;
        logic                   auto_mode;
        logic                   word_done;
        logic                   rb_armed;
        logic                   deferred;
        logic [WORD_BITS-1:0]   conv;
        logic                   sdo_bit;
        logic                   sdo_oe;
        analog_ctrl_t           actl;
        logic                   stall;
    } ctrl_state_t;

    ctrl_state_t cur;
    ctrl_state_t next_cur;
    pin_in_t     raw;

    logic        buf_in_valid;
    logic        buf_in_ready;
    logic [WORD_BITS-1:0] buf_in_data;
    logic        buf_out_valid;
    logic [WORD_BITS-1:0] buf_out_data;

    assign raw = '{serial_clk, frame_n, serial_in, load_strobe_n,
                   readback_en_n, output_clear_n, power_down_n};

    // Words waiting for the converter register; a full buffer raises load_stall
    dac_load_buffer #(.WIDTH(WORD_BITS)) u_load_buf (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in_data),
        .out_valid (buf_out_valid),
        .out_ready (1'b1),
        .out_data  (buf_out_data)
    );

    // Next-state logic on synchronised pins; edges come from sync2 versus last
    always_comb begin
        logic sclk_fall;
        logic sclk_rise;
        logic frame_fall;
        logic frame_rise;
        logic clr_fall;
        logic rb_fall;
        logic [WORD_BITS-1:0] code_mask;
        sclk_fall    = 1'b0;
        sclk_rise    = 1'b0;
        frame_fall   = 1'b0;
        frame_rise   = 1'b0;
        clr_fall     = 1'b0;
        rb_fall      = 1'b0;
        code_mask    = '0;
        buf_in_valid = 1'b0;
        buf_in_data  = '0;
        next_cur       = cur;
        next_cur.sync1 = raw;
        next_cur.sync2 = cur.sync1;
        next_cur.last  = cur.sync2;
        sclk_fall  = cur.last.serial_clk && !cur.sync2.serial_clk;
        sclk_rise  = !cur.last.serial_clk && cur.sync2.serial_clk;
        frame_fall = cur.last.frame_n && !cur.sync2.frame_n;
        frame_rise = !cur.last.frame_n && cur.sync2.frame_n;
        clr_fall   = cur.last.output_clear_n && !cur.sync2.output_clear_n;
        rb_fall    = cur.last.readback_en_n && !cur.sync2.readback_en_n;
        code_mask  = WORD_BITS'((1 << CODE_BITS) - 1);

        if (frame_fall) begin
            next_cur.auto_mode = !cur.sync2.load_strobe_n;
            next_cur.bit_count = '0;
            next_cur.word_done = 1'b0;
        end
        if (rb_fall) begin
            next_cur.rb_armed = 1'b1;
        end
        if (sclk_fall) begin
            if (cur.rb_armed && !cur.sync2.readback_en_n) begin
                next_cur.shift = cur.conv & code_mask;
                next_cur.rb_armed = 1'b0;
            end else if (!cur.sync2.frame_n || !cur.sync2.readback_en_n) begin
                next_cur.shift = {cur.shift[WORD_BITS-2:0], cur.sync2.serial_in};
                if (!cur.sync2.frame_n && cur.bit_count != 5'h10) begin
                    next_cur.bit_count = cur.bit_count + 5'h01;
                end
                if (!cur.sync2.frame_n && cur.bit_count == 5'h0F) begin
                    next_cur.word_done = 1'b1;
                end
            end
        end
        // MSB leaving the shift register, changed on falling edge
        if (sclk_fall && cur.sync2.readback_en_n) begin
            next_cur.sdo_bit = cur.shift[WORD_BITS-1];
        end
        // readback data advances on rising edge
        if (sclk_rise && !cur.sync2.readback_en_n && !cur.rb_armed) begin
            next_cur.sdo_bit = cur.shift[WORD_BITS-1];
        end
        // open drain: drive only a low
        next_cur.sdo_oe = !next_cur.sdo_bit;

        if (frame_rise && cur.auto_mode && cur.word_done) begin
            buf_in_valid = 1'b1;
            buf_in_data  = cur.shift;
        end else if (frame_rise && cur.word_done) begin
            next_cur.deferred = 1'b1;
        end
        // strobe low loads after a complete word
        if (!cur.sync2.load_strobe_n && cur.sync2.frame_n && cur.deferred && !frame_rise) begin
            buf_in_valid = 1'b1;
            buf_in_data  = cur.shift;
            if (buf_in_ready) begin
                next_cur.deferred = 1'b0;
            end
        end
        next_cur.stall = !buf_in_ready;
        if (buf_out_valid) begin
            next_cur.conv = buf_out_data & code_mask;
        end
        // clear gates the output only, registers kept
        if (clr_fall) begin
            next_cur.actl.clear_active = 1'b1;
        end else if (cur.sync2.output_clear_n) begin
            next_cur.actl.clear_active = 1'b0;
        end
        // power-down is a flag, no register touched
        next_cur.actl.powered_down = !cur.sync2.power_down_n;
        next_cur.actl.code = next_cur.conv;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
            cur.sync1 <= '1;
            cur.sync2 <= '1;
            cur.last  <= '1;
            cur.sdo_bit <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign serial_out_o  = 1'b0;
    assign serial_out_oe = cur.sdo_oe;
    assign analog_ctrl   = cur.actl;
    assign load_stall    = cur.stall;
endmodule

// file: tb/dac_serial_ctrl_properties.sv
`timescale 1ns/1ps
// Port-level checks beside the serial controller
module dac_serial_ctrl_properties
    import dac_ctrl_pkg::*;
(
    input wire logic                      ref_clk,
    input wire logic                      rst,
    input wire logic                      serial_clk,
    input wire logic                      frame_n,
    input wire logic                      serial_in,
    input wire logic                      load_strobe_n,
    input wire logic                      readback_en_n,
    input wire logic                      output_clear_n,
    input wire logic                      power_down_n,
    input wire logic                      serial_out_o,
    input wire logic                      serial_out_oe,
    input wire dac_ctrl_pkg::analog_ctrl_t analog_ctrl,
    input wire logic                      load_stall
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [4:0] sclk_quiet;
    logic [4:0] load_quiet;
    // Idle counters; the synchroniser delay is why the limits sit well above three
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sclk_quiet <= 5'h00;
            load_quiet <= 5'h00;
        end else begin
            sclk_quiet <= $changed(serial_clk) ? 5'h00 : sclk_quiet + {4'h0, sclk_quiet != 5'h1F};
            load_quiet <= ($fell(load_strobe_n) || $rose(frame_n)) ? 5'h00 : load_quiet + {4'h0, load_quiet != 5'h1F};
        end
    end
    sequence clear_seen;
        ##[1:5] analog_ctrl.clear_active;
    endsequence
    sequence pd_seen;
        ##[1:5] analog_ctrl.powered_down;
    endsequence
    open_drain_a: assert property (serial_out_o == 1'b0) else $error("serial data driven high");
    clear_entry_a: assert property ($fell(output_clear_n) |-> clear_seen) else $error("clear not taken");
    clear_hold_a: assert property ($rose(analog_ctrl.clear_active) |-> $stable(analog_ctrl.code)) else $error("clear moved code");
    pd_entry_a: assert property ($fell(power_down_n) |-> pd_seen) else $error("power-down not taken");
    pd_hold_a: assert property ($changed(analog_ctrl.powered_down) |-> $stable(analog_ctrl.code)) else $error("pd moved code");
    code_width_a: assert property (analog_ctrl.code[15:14] == 2'b00) else $error("code top bits set");
    load_cause_a: assert property (load_quiet > 5'h0C |-> $stable(analog_ctrl.code)) else $error("code moved unloaded");
    daisy_edge_a: assert property ($changed(serial_out_oe) |-> sclk_quiet < 5'h0A) else $error("data out moved idle");
endmodule

bind dac_serial_ctrl dac_serial_ctrl_properties props (.ref_clk(ref_clk), .rst(rst), .serial_clk(serial_clk),
    .frame_n(frame_n), .serial_in(serial_in), .load_strobe_n(load_strobe_n), .readback_en_n(readback_en_n),
    .output_clear_n(output_clear_n), .power_down_n(power_down_n), .serial_out_o(serial_out_o),
    .serial_out_oe(serial_out_oe), .analog_ctrl(analog_ctrl), .load_stall(load_stall));

// file: tb/host_port.sv
`timescale 1ns/1ps
// Host serial port; clock idles high and stands still between words
module host_port (
    input  wire logic ref_clk,
    input  wire logic pin,
    output logic      serial_clk,
    output logic      frame_n,
    output logic      serial_in,
    output logic      readback_en_n
);
    initial begin
        serial_clk = 1'b1;
        frame_n = 1'b1;
        serial_in = 1'b0;
        readback_en_n = 1'b1;
    end
    // One word at 160 ns per bit; pin sampled before each fall and each rise
    task automatic xfer(input logic [15:0] w, input bit rb, output logic [15:0] hi, output logic [15:0] lo);
        @(negedge ref_clk);
        // Frame or readback enable low for the whole word
        frame_n = rb;
        readback_en_n = !rb;
        repeat (4) @(negedge ref_clk);
        for (int i = 15; i >= 0; i--) begin
            // MSB first, held across the falling edge
            serial_in = w[i];
            repeat (4) @(negedge ref_clk);
            hi[i] = pin;
            serial_clk = 1'b0;
            repeat (4) @(negedge ref_clk);
            lo[i] = pin;
            serial_clk = 1'b1;
        end
        repeat (4) @(negedge ref_clk);
        frame_n = 1'b1;
        readback_en_n = 1'b1;
        // Released line flips so a stale bit cannot pass
        serial_in = !serial_in;
        repeat (12) @(negedge ref_clk);
    endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
    import dac_ctrl_pkg::*;
    logic ref_clk, rst, serial_clk, frame_n, serial_in, load_strobe_n, readback_en_n;
    logic output_clear_n, power_down_n, serial_out_o, serial_out_oe, load_stall;
    analog_ctrl_t analog_ctrl;
    logic [15:0]  prev_code, got, hi, lo, w, a;
    logic [15:0]  exp_q[$];
    int           bad_count, n_compared, cyc;
    // Open-drain pin with pull-up
    wire pin = serial_out_oe ? serial_out_o : 1'b1;
    dac_serial_ctrl DUT (.ref_clk(ref_clk), .rst(rst), .serial_clk(serial_clk), .frame_n(frame_n),
        .serial_in(serial_in), .load_strobe_n(load_strobe_n), .readback_en_n(readback_en_n),
        .output_clear_n(output_clear_n), .power_down_n(power_down_n), .serial_out_o(serial_out_o),
        .serial_out_oe(serial_out_oe), .analog_ctrl(analog_ctrl), .load_stall(load_stall));
    host_port HOST (.ref_clk(ref_clk), .pin(pin), .serial_clk(serial_clk), .frame_n(frame_n),
        .serial_in(serial_in), .readback_en_n(readback_en_n));
    task automatic complete_run();
        if (bad_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // Hang guard, well above the under one thousand cycles needed
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            complete_run();
        end
    end
    // Every code change must match the oldest expected load
    always @(negedge ref_clk) begin
        if (!rst && analog_ctrl.code !== prev_code) begin
            got = exp_q.size() > 0 ? exp_q.pop_front() : prev_code;
            `CHK(analog_ctrl.code, got)
            prev_code = analog_ctrl.code;
        end
    end
    initial begin
        rst = 1'b1;
        load_strobe_n = 1'b0;
        output_clear_n = 1'b1;
        power_down_n = 1'b1;
        prev_code = 16'h0000;
        void'($urandom(79));
        repeat (12) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        // Strobe tied low: back-to-back auto updates, daisy echo of the previous word
        // The shift register leaves reset empty, so the first frame echoes zeros
        a = 16'h0000;
        for (int k = 0; k < 4; k++) begin
            w = (k == 1) ? 16'hFFFF : 16'($urandom());
            exp_q.push_back({2'b00, w[13:0]});
            HOST.xfer(w, 1'b0, hi, lo);
            // Echo bit moves on each fall and stands until the next one
            `CHK(lo, a)
            `CHK(hi[14:0], a[15:1])
            a = w;
        end
        // Strobe high at frame fall defers the load until it falls
        load_strobe_n = 1'b1;
        w = 16'($urandom());
        HOST.xfer(w, 1'b0, hi, lo);
        `CHK(lo, a)
        `CHK(analog_ctrl.code, {2'b00, a[13:0]})
        exp_q.push_back({2'b00, w[13:0]});
        load_strobe_n = 1'b0;
        repeat (12) @(negedge ref_clk);
        `CHK(exp_q.size() == 0, 1'b1)
        a = w;
        // Readback with strobe high; shifting in the same word keeps any load harmless
        load_strobe_n = 1'b1;
        HOST.xfer(a, 1'b1, hi, lo);
        // First fall only loads the word, so the last bit is still on the pin after the frame
        `CHK({lo[14:0], pin}, {2'b00, a[13:0]})
        `CHK(hi[14:0], {2'b00, a[13:1]})
        // Clear and power-down keep the loaded code
        output_clear_n = 1'b0;
        power_down_n = 1'b0;
        repeat (8) @(negedge ref_clk);
        `CHK({analog_ctrl.clear_active, analog_ctrl.powered_down}, 2'b11)
        output_clear_n = 1'b1;
        power_down_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        `CHK(analog_ctrl, {2'b00, a[13:0], 2'b00})
        `CHK(exp_q.size() == 0, 1'b1)
        // Load buffer drains every cycle, so no frame was ever stalled
        `CHK(load_stall, 1'b0)
        complete_run();
    end
endmodule
